// >>> verilog/line_io_timing_defs.svh
// constants of the line pad timing source selection block
`ifndef LINE_IO_TIMING_DEFS_SVH
`define LINE_IO_TIMING_DEFS_SVH
`define LIT_ADDR_W 4
`define LIT_DATA_W 32
`define LIT_OFS_CTRL 4'h0
`define LIT_OFS_VALID 4'h4
`define LIT_OFS_SRC 4'h8
`define LIT_CTRL_LOOP 0
`define LIT_CTRL_MODE_LO 1
`define LIT_CTRL_MODE_HI 3
`define LIT_CTRL_BYP 4
`define LIT_CTRL_TL_SEL 5
`define LIT_CTRL_TF_SEL 6
`define LIT_CTRL_RF_SEL 7
`define LIT_CTRL_RESET 8'h00
`define LIT_VALID_TL_LO 0
`define LIT_VALID_TF_LO 8
`define LIT_VALID_RF_LO 16
`define LIT_SRC_TL_LO 0
`define LIT_SRC_TF_LO 4
`define LIT_SRC_RF_LO 8
`define LIT_MODE_OFF 3'h0
`define LIT_MODE_TX_SIDE 3'h1
`define LIT_MODE_LINE 3'h2
`define LIT_MODE_PAYLOAD 3'h3
`define LIT_MODE_DIAG 3'h4
`define LIT_MODE_DIAG_LINE 3'h6
// valid clock mask bits
`define LIT_CK_TLCO 5'h10
`define LIT_CK_TCO 5'h08
`define LIT_CK_RCO 5'h04
`define LIT_CK_RLCI 5'h02
`define LIT_CK_TCI 5'h01
`define LIT_CK_NONE 5'h00
`endif

// >>> verilog/line_io_timing_pkg.sv
// types for the line pad timing source selection block
package line_io_timing_pkg;
  // functional clock source of a pad group
  typedef enum logic [2:0] {
    SRC_RX_LINE = 3'h1,
    SRC_ADAPTER = 3'h2,
    SRC_TX_IN = 3'h4
  } clk_src_t;

  typedef struct packed {
    logic rx_framer_timing_select;
    logic tx_framer_timing_select;
    logic tx_line_timing_select;
    logic rate_adapter_bypass_select;
    logic [2:0] loopback_mode_field;
    logic loop_timing_enable;
  } cfg_t;

  // pads of one port, link side
  typedef struct packed {
    logic [1:0] rx_line;
    logic [1:0] tx_line;
    logic [1:0] tx_framer;
    logic [1:0] rx_framer;
  } pads_t;
endpackage

// >>> verilog/line_io_timing_source_select.sv
// line pad timing source selection for one port
`timescale 1ns/10ps
`default_nettype none
`include "line_io_timing_defs.svh"

module line_io_timing_source_select (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [`LIT_ADDR_W-1:0] addr, // register byte address
  input wire logic [`LIT_DATA_W-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [`LIT_DATA_W-1:0] rd_data, // read data, cycle after strobe
  input wire logic clk_link, // receive line clock input pin
  input wire line_io_timing_pkg::pads_t pad_in, // pads and core data in
  output line_io_timing_pkg::pads_t pad_out, // retimed pad data
  output logic [4:0] tx_line_valid, // valid clock pins, tx line pads
  output logic [4:0] tx_framer_valid, // valid clock pins, tx framer pads
  output logic [4:0] rx_framer_valid, // valid clock pins, rx framer pads
  output line_io_timing_pkg::clk_src_t tx_line_src, // tx line source
  output line_io_timing_pkg::clk_src_t tx_framer_src, // tx clock source
  output line_io_timing_pkg::clk_src_t rx_framer_src, // rx clock source
  output logic [2:0] link_timing_select // selects seen in link domain
);

  line_io_timing_pkg::cfg_t cfg_q;
  logic [`LIT_DATA_W-1:0] rd_data_q;
  logic [4:0] tl_valid_q;
  logic [4:0] tf_valid_q;
  logic [4:0] rf_valid_q;
  logic [4:0] tl_valid_d;
  logic [4:0] tf_valid_d;
  logic [4:0] rf_valid_d;
  line_io_timing_pkg::clk_src_t tl_src_q;
  line_io_timing_pkg::clk_src_t tf_src_q;
  line_io_timing_pkg::clk_src_t rf_src_q;
  line_io_timing_pkg::clk_src_t tl_src_d;
  line_io_timing_pkg::clk_src_t tf_src_d;
  line_io_timing_pkg::clk_src_t rf_src_d;
  logic [2:0] ts_meta_q;
  logic [2:0] ts_link_q;
  logic [1:0] rst_meta_q;
  logic link_rst_n_q;
  line_io_timing_pkg::pads_t pad_q;

  // clock derived internally: adapter or transmit input pin
  function automatic line_io_timing_pkg::clk_src_t tx_base(
    input logic byp
  );
    tx_base = byp ? line_io_timing_pkg::SRC_TX_IN
                  : line_io_timing_pkg::SRC_ADAPTER;
  endfunction

  // input-pin valid set when the group runs from the tx base clock
  function automatic logic [4:0] tx_in_valid(input logic byp);
    tx_in_valid = byp ? `LIT_CK_TCI : `LIT_CK_NONE;
  endfunction

  // functional sources of the three clock output pins
  always_comb begin
    if (cfg_q.loop_timing_enable ||
        cfg_q.loopback_mode_field[1:0] == 2'h2 ||
        cfg_q.loopback_mode_field == `LIT_MODE_PAYLOAD) begin
      tl_src_d = line_io_timing_pkg::SRC_RX_LINE;
    end else begin
      tl_src_d = tx_base(cfg_q.rate_adapter_bypass_select);
    end
    if (cfg_q.loop_timing_enable ||
        cfg_q.loopback_mode_field == `LIT_MODE_PAYLOAD) begin
      tf_src_d = line_io_timing_pkg::SRC_RX_LINE;
    end else begin
      tf_src_d = tx_base(cfg_q.rate_adapter_bypass_select);
    end
    if (cfg_q.loop_timing_enable ||
        !(cfg_q.loopback_mode_field[2] ||
          cfg_q.loopback_mode_field == `LIT_MODE_TX_SIDE)) begin
      rf_src_d = line_io_timing_pkg::SRC_RX_LINE;
    end else begin
      rf_src_d = tx_base(cfg_q.rate_adapter_bypass_select);
    end
  end

  // transmit line pad group valid clock pins
  always_comb begin
    if (!cfg_q.tx_line_timing_select) begin
      if (cfg_q.loop_timing_enable) begin
        tl_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
      end else begin
        unique case (cfg_q.loopback_mode_field)
          `LIT_MODE_DIAG: begin
            tl_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
          end
          `LIT_MODE_LINE, `LIT_MODE_PAYLOAD: begin
            tl_valid_d = `LIT_CK_TLCO | `LIT_CK_RCO;
          end
          `LIT_MODE_DIAG_LINE: begin
            tl_valid_d = `LIT_CK_TLCO;
          end
          default: begin
            tl_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO;
          end
        endcase
      end
    end else begin
      if (cfg_q.loop_timing_enable ||
          cfg_q.loopback_mode_field == `LIT_MODE_LINE ||
          cfg_q.loopback_mode_field == `LIT_MODE_PAYLOAD ||
          cfg_q.loopback_mode_field == `LIT_MODE_DIAG_LINE) begin
        tl_valid_d = `LIT_CK_RLCI;
      end else begin
        tl_valid_d = tx_in_valid(cfg_q.rate_adapter_bypass_select);
      end
    end
  end

  // transmit framer pad group valid clock pins
  always_comb begin
    if (!cfg_q.tx_framer_timing_select) begin
      if (cfg_q.loop_timing_enable) begin
        tf_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
      end else begin
        unique case (cfg_q.loopback_mode_field)
          `LIT_MODE_OFF: begin
            tf_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO;
          end
          `LIT_MODE_DIAG_LINE: begin
            tf_valid_d = `LIT_CK_TCO | `LIT_CK_RCO;
          end
          `LIT_MODE_LINE: begin
            tf_valid_d = `LIT_CK_TCO;
          end
          default: begin
            tf_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
          end
        endcase
      end
    end else begin
      if (cfg_q.loop_timing_enable ||
          cfg_q.loopback_mode_field == `LIT_MODE_PAYLOAD) begin
        tf_valid_d = `LIT_CK_RLCI;
      end else begin
        tf_valid_d = tx_in_valid(cfg_q.rate_adapter_bypass_select);
      end
    end
  end

  // receive framer pad group valid clock pins
  always_comb begin
    if (!cfg_q.rx_framer_timing_select) begin
      if (cfg_q.loop_timing_enable) begin
        rf_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
      end else begin
        unique case (cfg_q.loopback_mode_field)
          `LIT_MODE_OFF: begin
            rf_valid_d = `LIT_CK_RCO;
          end
          `LIT_MODE_DIAG_LINE: begin
            rf_valid_d = `LIT_CK_RCO | `LIT_CK_TCO;
          end
          `LIT_MODE_LINE: begin
            rf_valid_d = `LIT_CK_RCO | `LIT_CK_TLCO;
          end
          default: begin
            rf_valid_d = `LIT_CK_TLCO | `LIT_CK_TCO | `LIT_CK_RCO;
          end
        endcase
      end
    end else begin
      if (!cfg_q.loop_timing_enable &&
          (cfg_q.loopback_mode_field == `LIT_MODE_DIAG ||
           cfg_q.loopback_mode_field == `LIT_MODE_DIAG_LINE)) begin
        rf_valid_d = tx_in_valid(cfg_q.rate_adapter_bypass_select);
      end else begin
        rf_valid_d = `LIT_CK_RLCI;
      end
    end
  end

  // configuration register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_q <= line_io_timing_pkg::cfg_t'(`LIT_CTRL_RESET);
    end else if (wr_en && addr == `LIT_OFS_CTRL) begin
      cfg_q <= wr_data[`LIT_CTRL_RF_SEL:`LIT_CTRL_LOOP];
    end
  end

  // valid sets and sources, held in flops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tl_valid_q <= `LIT_CK_TLCO | `LIT_CK_TCO;
      tf_valid_q <= `LIT_CK_TLCO | `LIT_CK_TCO;
      rf_valid_q <= `LIT_CK_RCO;
      tl_src_q <= line_io_timing_pkg::SRC_ADAPTER;
      tf_src_q <= line_io_timing_pkg::SRC_ADAPTER;
      rf_src_q <= line_io_timing_pkg::SRC_RX_LINE;
    end else begin
      tl_valid_q <= tl_valid_d;
      tf_valid_q <= tf_valid_d;
      rf_valid_q <= rf_valid_d;
      tl_src_q <= tl_src_d;
      tf_src_q <= tf_src_d;
      rf_src_q <= rf_src_d;
    end
  end

  // read port, unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= '0;
      unique case (addr)
        `LIT_OFS_CTRL: begin
          rd_data_q[`LIT_CTRL_RF_SEL:`LIT_CTRL_LOOP] <= cfg_q;
        end
        `LIT_OFS_VALID: begin
          rd_data_q[`LIT_VALID_TL_LO +: 5] <= tl_valid_q;
          rd_data_q[`LIT_VALID_TF_LO +: 5] <= tf_valid_q;
          rd_data_q[`LIT_VALID_RF_LO +: 5] <= rf_valid_q;
        end
        `LIT_OFS_SRC: begin
          rd_data_q[`LIT_SRC_TL_LO +: 3] <= tl_src_q;
          rd_data_q[`LIT_SRC_TF_LO +: 3] <= tf_src_q;
          rd_data_q[`LIT_SRC_RF_LO +: 3] <= rf_src_q;
        end
        default: begin
          rd_data_q <= '0;
        end
      endcase
    end else begin
      rd_data_q <= '0;
    end
  end

  // reset into link domain, released after three link edges
  always_ff @(posedge clk_link) begin
    rst_meta_q <= {rst_meta_q[0], reset_n};
    link_rst_n_q <= rst_meta_q[1];
  end

  // timing selects cross as quasi-static levels
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      ts_meta_q <= 3'h0;
      ts_link_q <= 3'h0;
    end else begin
      ts_meta_q <= {cfg_q.rx_framer_timing_select,
                    cfg_q.tx_framer_timing_select,
                    cfg_q.tx_line_timing_select};
      ts_link_q <= ts_meta_q;
    end
  end

  // one retime flop per pad, on the pin clock before any tree
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      pad_q <= '0;
    end else begin
      pad_q.rx_line <= pad_in.rx_line;
      pad_q.tx_line <= pad_in.tx_line;
      pad_q.tx_framer <= pad_in.tx_framer;
      pad_q.rx_framer <= pad_in.rx_framer;
    end
  end

  assign rd_data = rd_data_q;
  assign pad_out = pad_q;
  assign tx_line_valid = tl_valid_q;
  assign tx_framer_valid = tf_valid_q;
  assign rx_framer_valid = rf_valid_q;
  assign tx_line_src = tl_src_q;
  assign tx_framer_src = tf_src_q;
  assign rx_framer_src = rf_src_q;
  assign link_timing_select = ts_link_q;

endmodule
`default_nettype wire

// >>> testbench/line_io_timing_chk.sv
// checker for the line pad timing source selection block
`timescale 1ns/10ps
`default_nettype none
module line_io_timing_chk (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // reset, active low
  input wire logic [3:0] addr, // bus address
  input wire logic rd_en, // read strobe
  input wire logic wr_en, // write strobe
  input wire logic [31:0] rd_data, // read data
  input wire logic clk_link, // link clock
  input wire line_io_timing_pkg::pads_t pad_in, // pads in
  input wire line_io_timing_pkg::pads_t pad_out, // retimed pads
  input wire logic [4:0] tx_line_valid, // tx line mask
  input wire logic [4:0] tx_framer_valid, // tx framer mask
  input wire logic [4:0] rx_framer_valid, // rx framer mask
  input wire line_io_timing_pkg::clk_src_t tx_line_src, // tx line source
  input wire line_io_timing_pkg::clk_src_t tx_framer_src, // tx source
  input wire line_io_timing_pkg::clk_src_t rx_framer_src // rx source
);
  tl_input_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_line_valid[4:2] == 3'h0 |-> tx_line_valid == {3'h0,
    tx_line_src == line_io_timing_pkg::SRC_RX_LINE,
    tx_line_src == line_io_timing_pkg::SRC_TX_IN})
    else $error("tx line input mask disagrees with source");
  tf_input_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_framer_valid[4:2] == 3'h0 |-> tx_framer_valid == {3'h0,
    tx_framer_src == line_io_timing_pkg::SRC_RX_LINE,
    tx_framer_src == line_io_timing_pkg::SRC_TX_IN})
    else $error("tx framer input mask disagrees with source");
  rf_input_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_framer_valid[4:2] == 3'h0 && rx_framer_valid != 5'h02 |->
    rx_framer_src != line_io_timing_pkg::SRC_RX_LINE && rx_framer_valid
    == {4'h0, rx_framer_src == line_io_timing_pkg::SRC_TX_IN})
    else $error("rx framer input mask disagrees with source");
  tl_output_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_line_valid[4:2] != 3'h0 |-> tx_line_valid[4] && !tx_line_valid[1:0])
    else $error("tx line output mask wrong");
  tf_output_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_framer_valid[4:2] != 3'h0 |-> tx_framer_valid[3] && !tx_framer_valid[1:0])
    else $error("tx framer output mask wrong");
  rf_output_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_framer_valid[4:2] != 3'h0 |-> rx_framer_valid[2] && !rx_framer_valid[1:0])
    else $error("rx framer output mask wrong");
  valid_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(rd_en) && $past(addr) == 4'h4 |-> rd_data == {11'h0,
    $past(rx_framer_valid), 3'h0, $past(tx_framer_valid), 3'h0,
    $past(tx_line_valid)}) else $error("valid register read wrong");
  cfg_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$past(wr_en) && !$past(wr_en, 2) |-> $stable(tx_line_valid) &&
    $stable(rx_framer_valid) && $stable(tx_framer_src))
    else $error("selection changed without a write");
  pad_retime_a: assert property (@(posedge clk_link) disable iff (!reset_n)
    $past(reset_n, 5) |-> pad_out == $past(pad_in))
    else $error("pad not retimed by one link flop");
  cover property (@(posedge clk_sys) tx_line_valid == 5'h00);
  cover property (@(posedge clk_sys) tx_framer_valid == 5'h1C);
  cover property (@(posedge clk_sys) rx_framer_valid == 5'h01);
endmodule
`default_nettype wire

// >>> testbench/line_far_end_model.sv
// far-end line interface model driving the link pads
`timescale 1ns/10ps
`default_nettype none
module line_far_end_model #(parameter int SEED = 32'h2ff72511) (
  input wire logic clk_link, // receive line clock input pin
  output var line_io_timing_pkg::pads_t pad_in // pad data to the device
);
  integer seed = SEED;
  // data launched just after each rising edge of the rx line clock input
  initial begin
    pad_in = '0;
    forever begin
      @(posedge clk_link);
      pad_in <= line_io_timing_pkg::pads_t'(8'($random(seed)));
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_line_io_timing_source_select.sv
// self-checking bench for the line pad timing source selection block
`timescale 1ns/10ps
`default_nettype none
module test_line_io_timing_source_select;
  logic clk_sys = 1'b0, clk_link = 1'b0, reset_n = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0, rd_data, rnd;
  logic [4:0] tlv, tfv, rfv;
  logic [2:0] lts;
  line_io_timing_pkg::pads_t pad_in, pad_out;
  line_io_timing_pkg::clk_src_t tls, tfs, rfs;
  integer seed = 32'h2ff72511, miscompares = 0, samples_checked = 0;
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #15 clk_link = ~clk_link;
  end
  line_io_timing_source_select dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .clk_link(clk_link), .pad_in(pad_in),
    .pad_out(pad_out), .tx_line_valid(tlv), .tx_framer_valid(tfv),
    .rx_framer_valid(rfv), .tx_line_src(tls), .tx_framer_src(tfs),
    .rx_framer_src(rfs), .link_timing_select(lts));
  line_far_end_model far_u (.clk_link(clk_link), .pad_in(pad_in));
  function automatic logic all3(input logic [7:0] c);
    return c[0] || c[3:1] == 3'h1 || c[3:1] == 3'h3 ||
      (c[3] && c[3:1] != 3'h6);
  endfunction
  function automatic logic [4:0] vtl(input logic [7:0] c);
    if (c[5]) return (c[0] || c[3:1] == 3'h2 || c[3:1] == 3'h3 ||
      c[3:1] == 3'h6) ? 5'h02 : {4'h0, c[4]};
    if (c[0] || c[3:1] == 3'h4) return 5'h1C;
    if (c[3:1] == 3'h2 || c[3:1] == 3'h3) return 5'h14;
    return (c[3:1] == 3'h6) ? 5'h10 : 5'h18;
  endfunction
  function automatic logic [4:0] vtf(input logic [7:0] c);
    if (c[6]) return (c[0] || c[3:1] == 3'h3) ? 5'h02 : {4'h0, c[4]};
    if (all3(c)) return 5'h1C;
    if (c[3:1] == 3'h6) return 5'h0C;
    return (c[3:1] == 3'h2) ? 5'h08 : 5'h18;
  endfunction
  function automatic logic [4:0] vrf(input logic [7:0] c);
    if (c[7]) return (!c[0] && (c[3:1] == 3'h4 || c[3:1] == 3'h6)) ?
      {4'h0, c[4]} : 5'h02;
    if (all3(c)) return 5'h1C;
    if (c[3:1] == 3'h6) return 5'h0C;
    return (c[3:1] == 3'h2) ? 5'h14 : 5'h04;
  endfunction
  function automatic logic [8:0] srcs(input logic [7:0] c);
    logic [2:0] s;
    s = c[4] ? 3'h4 : 3'h2;
    return {(c[0] || c[2:1] == 2'h2 || c[3:1] == 3'h3) ? 3'h1 : s,
      (c[0] || c[3:1] == 3'h3) ? 3'h1 : s,
      (!c[0] && (c[3] || c[3:1] == 3'h1)) ? s : 3'h1};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic ports(input logic [7:0] c);
    logic [8:0] s;
    s = srcs(c);
    chk({27'h0, tlv}, {27'h0, vtl(c)});
    chk({27'h0, tfv}, {27'h0, vtf(c)});
    chk({27'h0, rfv}, {27'h0, vrf(c)});
    chk({23'h0, tls, tfs, rfs}, {23'h0, s});
  endtask
  task automatic all_regs(input logic [7:0] c);
    logic [8:0] s;
    s = srcs(c);
    rd(4'h0, {24'h0, c});
    ports(c);
    rd(4'h4, {11'h0, vrf(c), 3'h0, vtf(c), 3'h0, vtl(c)});
    rd(4'h8, {21'h0, s[2:0], 1'h0, s[5:3], 1'h0, s[8:6]});
    chk({29'h0, lts}, {29'h0, c[7:5]});
  endtask
  task results;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    all_regs(8'h00);
    for (int i = 0; i < 256; i++) begin
      rnd = $random(seed);
      wr(4'h0, {rnd[31:8], i[7:0]});
      all_regs(i[7:0]);
    end
    rnd = $random(seed);
    wr(4'h4, rnd);
    wr(4'h8, rnd);
    wr(4'hC, rnd);
    all_regs(8'hFF);
    rd(4'hC, 32'h0);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 ports(8'h00);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    all_regs(8'h00);
    results;
  end
  initial begin
    #600000;
    miscompares++;
    results;
  end
endmodule
bind line_io_timing_source_select line_io_timing_chk chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .rd_en(rd_en),
  .wr_en(wr_en), .rd_data(rd_data), .clk_link(clk_link), .pad_in(pad_in),
  .pad_out(pad_out), .tx_line_valid(tx_line_valid),
  .tx_framer_valid(tx_framer_valid), .rx_framer_valid(rx_framer_valid),
  .tx_line_src(tx_line_src), .tx_framer_src(tx_framer_src),
  .rx_framer_src(rx_framer_src));
`default_nettype wire
